// ==== common/dpll_pkg.sv ====
// Purpose: Shared constants and types for the loop mode and steering block
// Assumes: AXI4-Lite register slave, 32-bit data, byte addresses below
// Notes:   Hi words of 40-bit values hold bits 39:32 in their low byte
package dpll_pkg;
  localparam int WORD_W = 40;
  localparam int STEP_W = 38;
  localparam int PRE_W  = 5;
  localparam int HIST_SHIFT = 4;

  localparam logic [7:0] OFF_CTRL    = 8'h00;
  localparam logic [7:0] OFF_STATUS  = 8'h04;
  localparam logic [7:0] OFF_TRIG    = 8'h08;
  localparam logic [7:0] OFF_STEP_LO = 8'h0C;
  localparam logic [7:0] OFF_STEP_HI = 8'h10;
  localparam logic [7:0] OFF_FREE_LO = 8'h14;
  localparam logic [7:0] OFF_FREE_HI = 8'h18;
  localparam logic [7:0] OFF_RNUM_LO = 8'h1C;
  localparam logic [7:0] OFF_RNUM_HI = 8'h20;
  localparam logic [7:0] OFF_ONUM_LO = 8'h24;
  localparam logic [7:0] OFF_ONUM_HI = 8'h28;
  localparam logic [7:0] OFF_RDEN_LO = 8'h2C;
  localparam logic [7:0] OFF_RDEN_HI = 8'h30;
  localparam logic [7:0] OFF_FTHR    = 8'h34;
  localparam logic [7:0] OFF_AVG_LO  = 8'h38;
  localparam logic [7:0] OFF_AVG_HI  = 8'h3C;

  localparam int CTRL_HIST_EN  = 0;
  localparam int CTRL_TEMP_COMPENSATED_OSC_USE = 1;
  localparam int CTRL_STEER_EN = 2;
  localparam int CTRL_PIN_EN   = 3;
  localparam int CTRL_LOOP_SEL = 4;
  localparam int CTRL_RPRE_LSB = 8;
  localparam int CTRL_OPRE_LSB = 16;

  localparam logic [31:0] RST_CTRL = 32'h0002_0200;
  localparam logic [31:0] RST_FTHR = 32'h0000_1000;
  localparam logic [4:0]  PRE_MIN  = 5'h02;
  localparam logic [4:0]  PRE_MAX  = 5'h11;
  localparam logic [40:0] DEN_FULL = 41'h100_0000_0000;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    MODE_FREE_RUN,
    MODE_ACQUIRE,
    MODE_LOCKED,
    MODE_HOLDOVER
  } chan_mode_t;
endpackage

// ==== common/step_pin_if.sv ====
// Purpose: Carries raw steering pins in and their rising-edge pulses out
// Assumes: Bit order ch1 up, ch1 down, ch2 up, ch2 down
// Notes:   Pulses are one cycle wide
`timescale 1ns/100ps
interface step_pin_if;
  logic [3:0] pins;
  logic [3:0] rise;
  modport sync (input pins, output rise);
  modport ctrl (output pins, input rise);
endinterface

// ==== core/dpll_mode_ctrl.sv ====
// Purpose: Mode sequencing and oscillator steering for one loop channel
// Assumes: Loop detectors and tuning word arrive synchronous to the clock
// Notes:   Registers reached over AXI4-Lite
`timescale 1ns/100ps
module dpll_mode_ctrl #(
  parameter int CHANNEL = 1
) (
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst_n,
  input  wire logic [7:0]  i_s_axi_awaddr,
  input  wire logic        i_s_axi_awvalid,
  output logic             o_s_axi_awready,
  input  wire logic [31:0] i_s_axi_wdata,
  input  wire logic [3:0]  i_s_axi_wstrb,
  input  wire logic        i_s_axi_wvalid,
  output logic             o_s_axi_wready,
  output logic [1:0]       o_s_axi_bresp,
  output logic             o_s_axi_bvalid,
  input  wire logic        i_s_axi_bready,
  input  wire logic [7:0]  i_s_axi_araddr,
  input  wire logic        i_s_axi_arvalid,
  output logic             o_s_axi_arready,
  output logic [31:0]      o_s_axi_rdata,
  output logic [1:0]       o_s_axi_rresp,
  output logic             o_s_axi_rvalid,
  input  wire logic        i_s_axi_rready,
  input  wire logic        i_xo_present,
  input  wire logic        i_temp_compensated_osc_present,
  input  wire logic [3:0]  i_ref_valid,
  input  wire logic        i_freq_lock_det,
  input  wire logic        i_phase_lock_det,
  input  wire logic [39:0] i_tuning_word,
  input  wire logic        i_ch1_step_up_pin,
  input  wire logic        i_ch1_step_down_pin,
  input  wire logic        i_ch2_step_up_pin,
  input  wire logic        i_ch2_step_down_pin,
  output logic             o_analog_loop_lock_en,
  output logic             o_osc_loop_lock_en,
  output logic [3:0]       o_ref_qualified,
  output logic [1:0]       o_mode,
  output logic             o_fast_acquire,
  output logic             o_freq_lock_lost_flag,
  output logic             o_phase_lock_lost_flag,
  output logic             o_holdover_load,
  output logic [39:0]      o_holdover_word,
  output logic [39:0]      o_ref_num,
  output logic [39:0]      o_osc_num,
  output logic [40:0]      o_ref_den,
  output logic [40:0]      o_osc_den,
  output logic [4:0]       o_ref_prescale,
  output logic [4:0]       o_osc_prescale
);
  typedef struct packed {
    logic                 aw_done;
    logic [7:0]           aw_addr;
    logic                 w_done;
    logic [31:0]          w_data;
    logic [3:0]           w_strb;
    logic                 b_valid;
    logic [1:0]           b_resp;
    logic                 r_valid;
    logic [31:0]          r_data;
    logic [1:0]           r_resp;
    logic [31:0]          ctrl;
    logic [37:0]          step;
    logic [39:0]          free_word;
    logic [39:0]          ref_num;
    logic [39:0]          osc_num;
    logic [39:0]          ref_den;
    logic [31:0]          fthr;
    logic [39:0]          avg;
    logic [39:0]          hold_word;
    logic                 hold_load;
    logic                 hist_valid;
    dpll_pkg::chan_mode_t mode;
    logic [3:0]           ref_q;
    logic                 analog_lock;
    logic                 osc_lock;
    logic                 fll;
    logic                 pll;
  } ctrl_state_t;

  ctrl_state_t s_reg;
  ctrl_state_t s_next;

  step_pin_if pin_bus ();

  assign pin_bus.pins = {i_ch2_step_down_pin, i_ch2_step_up_pin,
                         i_ch1_step_down_pin, i_ch1_step_up_pin};

  step_pin_sync u_pin_sync (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .pin_bus   (pin_bus.sync)
  );

  function automatic logic [31:0] merge(input logic [31:0] old_w,
                                        input logic [31:0] new_w,
                                        input logic [3:0]  strb);
    logic [31:0] res;
    res = old_w;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = new_w[8*b +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic [4:0] clamp_pre(input logic [4:0] v);
    logic [4:0] res;
    res = v;
    if (v < dpll_pkg::PRE_MIN) begin
      res = dpll_pkg::PRE_MIN;
    end else if (v > dpll_pkg::PRE_MAX) begin
      res = dpll_pkg::PRE_MAX;
    end
    return res;
  endfunction

  logic        pin_up;
  logic        pin_down;
  logic        sw_up;
  logic        sw_down;
  logic        num_written;
  logic        any_ref;
  logic [31:0] wr_word;
  logic [31:0] rd_word;
  logic        rd_ok;
  logic [39:0] drift;
  logic [39:0] diff;
  logic        up;
  logic        down;

  // Each instance listens only to its own channel's pin pair
  assign pin_up   = (CHANNEL == 1) ? pin_bus.rise[0] : pin_bus.rise[2];
  assign pin_down = (CHANNEL == 1) ? pin_bus.rise[1] : pin_bus.rise[3];
  assign any_ref  = |i_ref_valid;

  always_comb begin
    rd_ok = 1'b1;
    unique case (i_s_axi_araddr)
      dpll_pkg::OFF_CTRL:    rd_word = s_reg.ctrl;
      dpll_pkg::OFF_STATUS:  rd_word = {20'h00000, s_reg.ref_q,
                                        s_reg.mode == dpll_pkg::MODE_ACQUIRE,
                                        s_reg.osc_lock, s_reg.analog_lock,
                                        s_reg.hist_valid, s_reg.pll,
                                        s_reg.fll, s_reg.mode};
      dpll_pkg::OFF_TRIG:    rd_word = 32'h00000000;
      dpll_pkg::OFF_STEP_LO: rd_word = s_reg.step[31:0];
      dpll_pkg::OFF_STEP_HI: rd_word = {26'h0000000, s_reg.step[37:32]};
      dpll_pkg::OFF_FREE_LO: rd_word = s_reg.free_word[31:0];
      dpll_pkg::OFF_FREE_HI: rd_word = {24'h000000, s_reg.free_word[39:32]};
      dpll_pkg::OFF_RNUM_LO: rd_word = s_reg.ref_num[31:0];
      dpll_pkg::OFF_RNUM_HI: rd_word = {24'h000000, s_reg.ref_num[39:32]};
      dpll_pkg::OFF_ONUM_LO: rd_word = s_reg.osc_num[31:0];
      dpll_pkg::OFF_ONUM_HI: rd_word = {24'h000000, s_reg.osc_num[39:32]};
      dpll_pkg::OFF_RDEN_LO: rd_word = s_reg.ref_den[31:0];
      dpll_pkg::OFF_RDEN_HI: rd_word = {24'h000000, s_reg.ref_den[39:32]};
      dpll_pkg::OFF_FTHR:    rd_word = s_reg.fthr;
      dpll_pkg::OFF_AVG_LO:  rd_word = s_reg.avg[31:0];
      dpll_pkg::OFF_AVG_HI:  rd_word = {24'h000000, s_reg.avg[39:32]};
      default: begin
        rd_word = 32'h00000000;
        rd_ok   = 1'b0;
      end
    endcase
  end

  always_comb begin
    s_next      = s_reg;
    sw_up       = 1'b0;
    sw_down     = 1'b0;
    num_written = 1'b0;
    wr_word     = 32'h00000000;
    drift       = 40'h0000000000;
    diff        = 40'h0000000000;
    up          = 1'b0;
    down        = 1'b0;

    // Address and data may arrive in either order
    if (i_s_axi_awvalid && o_s_axi_awready) begin
      s_next.aw_done = 1'b1;
      s_next.aw_addr = i_s_axi_awaddr;
    end
    if (i_s_axi_wvalid && o_s_axi_wready) begin
      s_next.w_done = 1'b1;
      s_next.w_data = i_s_axi_wdata;
      s_next.w_strb = i_s_axi_wstrb;
    end
    if (s_reg.b_valid && i_s_axi_bready) begin
      s_next.b_valid = 1'b0;
    end
    if (s_reg.r_valid && i_s_axi_rready) begin
      s_next.r_valid = 1'b0;
    end
    if (i_s_axi_arvalid && o_s_axi_arready) begin
      s_next.r_valid = 1'b1;
      s_next.r_data  = rd_word;
      s_next.r_resp  = rd_ok ? dpll_pkg::RESP_OKAY : dpll_pkg::RESP_SLVERR;
    end

    if (s_reg.aw_done && s_reg.w_done && !s_reg.b_valid) begin
      s_next.aw_done = 1'b0;
      s_next.w_done  = 1'b0;
      s_next.b_valid = 1'b1;
      s_next.b_resp  = dpll_pkg::RESP_OKAY;
      unique case (s_reg.aw_addr)
        dpll_pkg::OFF_CTRL: begin
          wr_word = merge(s_reg.ctrl, s_reg.w_data, s_reg.w_strb);
          s_next.ctrl = wr_word;
          // Out-of-range prescaler values are pulled to the limits
          s_next.ctrl[dpll_pkg::CTRL_RPRE_LSB +: 5] =
            clamp_pre(wr_word[dpll_pkg::CTRL_RPRE_LSB +: 5]);
          s_next.ctrl[dpll_pkg::CTRL_OPRE_LSB +: 5] =
            clamp_pre(wr_word[dpll_pkg::CTRL_OPRE_LSB +: 5]);
        end
        dpll_pkg::OFF_TRIG: begin
          if (s_reg.w_strb[0]) begin
            sw_up   = ~s_reg.w_data[0];
            sw_down = s_reg.w_data[0];
          end
        end
        dpll_pkg::OFF_STEP_LO: begin
          s_next.step[31:0] = merge(s_reg.step[31:0], s_reg.w_data,
                                    s_reg.w_strb);
        end
        dpll_pkg::OFF_STEP_HI: begin
          if (s_reg.w_strb[0]) begin
            s_next.step[37:32] = s_reg.w_data[5:0];
          end
        end
        dpll_pkg::OFF_FREE_LO: begin
          s_next.free_word[31:0] = merge(s_reg.free_word[31:0],
                                         s_reg.w_data, s_reg.w_strb);
        end
        dpll_pkg::OFF_FREE_HI: begin
          if (s_reg.w_strb[0]) begin
            s_next.free_word[39:32] = s_reg.w_data[7:0];
          end
        end
        dpll_pkg::OFF_RNUM_LO: begin
          num_written = 1'b1;
          s_next.ref_num[31:0] = merge(s_reg.ref_num[31:0],
                                       s_reg.w_data, s_reg.w_strb);
        end
        dpll_pkg::OFF_RNUM_HI: begin
          num_written = 1'b1;
          if (s_reg.w_strb[0]) begin
            s_next.ref_num[39:32] = s_reg.w_data[7:0];
          end
        end
        dpll_pkg::OFF_ONUM_LO: begin
          num_written = 1'b1;
          s_next.osc_num[31:0] = merge(s_reg.osc_num[31:0],
                                       s_reg.w_data, s_reg.w_strb);
        end
        dpll_pkg::OFF_ONUM_HI: begin
          num_written = 1'b1;
          if (s_reg.w_strb[0]) begin
            s_next.osc_num[39:32] = s_reg.w_data[7:0];
          end
        end
        dpll_pkg::OFF_RDEN_LO: begin
          s_next.ref_den[31:0] = merge(s_reg.ref_den[31:0],
                                       s_reg.w_data, s_reg.w_strb);
        end
        dpll_pkg::OFF_RDEN_HI: begin
          if (s_reg.w_strb[0]) begin
            s_next.ref_den[39:32] = s_reg.w_data[7:0];
          end
        end
        dpll_pkg::OFF_FTHR: begin
          s_next.fthr = merge(s_reg.fthr, s_reg.w_data, s_reg.w_strb);
        end
        dpll_pkg::OFF_STATUS, dpll_pkg::OFF_AVG_LO,
        dpll_pkg::OFF_AVG_HI: begin
          s_next.b_resp = dpll_pkg::RESP_OKAY;
        end
        default: begin
          s_next.b_resp = dpll_pkg::RESP_SLVERR;
        end
      endcase
    end

    // Lock enables follow the monitors so a lost oscillator drops lock
    s_next.analog_lock = i_xo_present;
    s_next.osc_lock = s_reg.ctrl[dpll_pkg::CTRL_TEMP_COMPENSATED_OSC_USE]
                      & i_temp_compensated_osc_present;

    s_next.hold_load = 1'b0;
    unique case (s_reg.mode)
      dpll_pkg::MODE_FREE_RUN: begin
        if (any_ref && s_reg.analog_lock) begin
          s_next.mode = dpll_pkg::MODE_ACQUIRE;
        end
      end
      dpll_pkg::MODE_ACQUIRE, dpll_pkg::MODE_LOCKED: begin
        if (!any_ref) begin
          s_next.mode      = dpll_pkg::MODE_HOLDOVER;
          s_next.hold_load = 1'b1;
          s_next.hold_word = s_reg.hist_valid ? s_reg.avg
                                              : s_reg.free_word;
        end else if (s_reg.mode == dpll_pkg::MODE_ACQUIRE
                     && i_phase_lock_det) begin
          s_next.mode = dpll_pkg::MODE_LOCKED;
        end
      end
      dpll_pkg::MODE_HOLDOVER: begin
        // Loop re-enters fast acquisition from the held word
        if (any_ref) begin
          s_next.mode = dpll_pkg::MODE_ACQUIRE;
        end
      end
    endcase

    // No reference is reported qualified while free-running
    s_next.ref_q = (s_next.mode == dpll_pkg::MODE_FREE_RUN) ? 4'h0
                                                            : i_ref_valid;

    if (s_next.mode == dpll_pkg::MODE_HOLDOVER) begin
      drift = i_tuning_word - s_next.hold_word;
      if (drift[39]) begin
        drift = 40'h0000000000 - drift;
      end
      s_next.pll = 1'b1;
      s_next.fll = drift > {8'h00, s_reg.fthr};
    end else if (s_next.mode == dpll_pkg::MODE_FREE_RUN) begin
      s_next.pll = 1'b1;
      s_next.fll = 1'b1;
    end else begin
      s_next.pll = ~i_phase_lock_det;
      s_next.fll = ~i_freq_lock_det;
    end

    // Exponential average of the tuning word after frequency lock
    if (!s_reg.ctrl[dpll_pkg::CTRL_HIST_EN]) begin
      s_next.hist_valid = 1'b0;
    end else if (s_reg.mode == dpll_pkg::MODE_LOCKED && !s_reg.fll) begin
      if (!s_reg.hist_valid) begin
        s_next.avg        = i_tuning_word;
        s_next.hist_valid = 1'b1;
      end else begin
        diff = i_tuning_word - s_reg.avg;
        s_next.avg = s_reg.avg + 40'($signed(diff) >>> dpll_pkg::HIST_SHIFT);
      end
    end

    // Up and down in one cycle cancel; a direct write beats a step
    if (s_reg.ctrl[dpll_pkg::CTRL_STEER_EN]
        && s_reg.mode == dpll_pkg::MODE_LOCKED && !num_written) begin
      up   = sw_up | (s_reg.ctrl[dpll_pkg::CTRL_PIN_EN] & pin_up);
      down = sw_down | (s_reg.ctrl[dpll_pkg::CTRL_PIN_EN] & pin_down);
      if (up != down) begin
        if (s_reg.ctrl[dpll_pkg::CTRL_LOOP_SEL]) begin
          s_next.ref_num = up ? s_reg.ref_num + {2'h0, s_reg.step}
                              : s_reg.ref_num - {2'h0, s_reg.step};
        end else begin
          s_next.osc_num = up ? s_reg.osc_num + {2'h0, s_reg.step}
                              : s_reg.osc_num - {2'h0, s_reg.step};
        end
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_reg      <= '0;
      s_reg.ctrl <= dpll_pkg::RST_CTRL;
      s_reg.fthr <= dpll_pkg::RST_FTHR;
      s_reg.mode <= dpll_pkg::MODE_FREE_RUN;
      s_reg.fll  <= 1'b1;
      s_reg.pll  <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign o_s_axi_awready = !s_reg.aw_done && !s_reg.b_valid;
  assign o_s_axi_wready  = !s_reg.w_done && !s_reg.b_valid;
  assign o_s_axi_bvalid  = s_reg.b_valid;
  assign o_s_axi_bresp   = s_reg.b_resp;
  assign o_s_axi_arready = !s_reg.r_valid;
  assign o_s_axi_rvalid  = s_reg.r_valid;
  assign o_s_axi_rdata   = s_reg.r_data;
  assign o_s_axi_rresp   = s_reg.r_resp;

  assign o_analog_loop_lock_en  = s_reg.analog_lock;
  assign o_osc_loop_lock_en     = s_reg.osc_lock;
  assign o_ref_qualified        = s_reg.ref_q;
  assign o_mode                 = s_reg.mode;
  assign o_fast_acquire         = s_reg.mode == dpll_pkg::MODE_ACQUIRE;
  assign o_freq_lock_lost_flag  = s_reg.fll;
  assign o_phase_lock_lost_flag = s_reg.pll;
  assign o_holdover_load        = s_reg.hold_load;
  assign o_holdover_word        = s_reg.hold_word;
  assign o_ref_num              = s_reg.ref_num;
  assign o_osc_num              = s_reg.osc_num;
  // Zero stands for the full 2^40 span
  assign o_ref_den = (s_reg.ref_den == 40'h0000000000) ? dpll_pkg::DEN_FULL
                                                      : {1'b0, s_reg.ref_den};
  assign o_osc_den      = dpll_pkg::DEN_FULL;
  assign o_ref_prescale = s_reg.ctrl[dpll_pkg::CTRL_RPRE_LSB +: 5];
  assign o_osc_prescale = s_reg.ctrl[dpll_pkg::CTRL_OPRE_LSB +: 5];
endmodule

// ==== core/step_pin_sync.sv ====
// Purpose: Synchronise the step pins and detect their rising edges
// Assumes: Pulses stay high longer than two clock periods
// Notes:   First stage feeds only the second stage
`timescale 1ns/100ps
module step_pin_sync (
  input  wire logic i_sys_clk,
  input  wire logic i_rst_n,
  step_pin_if.sync  pin_bus
);
  typedef struct packed {
    logic [3:0] meta;
    logic [3:0] sync;
    logic [3:0] prev;
  } sync_state_t;

  sync_state_t s_reg;
  sync_state_t s_next;

  always_comb begin
    s_next      = s_reg;
    s_next.meta = pin_bus.pins;
    s_next.sync = s_reg.meta;
    s_next.prev = s_reg.sync;
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // One pulse per qualifying high level
  for (genvar g = 0; g < 4; g++) begin : g_edge
    assign pin_bus.rise[g] = s_reg.sync[g] & ~s_reg.prev[g];
  end
endmodule

// ==== test/dpll_mode_ctrl_assertions.sv ====
// Purpose: Timing relations on mode, flag and steering outputs
// Assumes: One clock domain, asynchronous active-low reset
// Notes:   Bound to every controller instance
`timescale 1ns/100ps
module dpll_mode_ctrl_assertions (
  input wire logic        i_sys_clk,
  input wire logic        i_rst_n,
  input wire logic [3:0]  i_ref_valid,
  input wire logic        i_xo_present,
  input wire logic        o_analog_loop_lock_en,
  input wire logic [3:0]  o_ref_qualified,
  input wire logic [1:0]  o_mode,
  input wire logic        o_fast_acquire,
  input wire logic        o_phase_lock_lost_flag,
  input wire logic        o_holdover_load,
  input wire logic [39:0] o_osc_num,
  input wire logic [39:0] o_ref_num,
  input wire logic        o_s_axi_bvalid,
  input wire logic [40:0] o_osc_den,
  input wire logic [4:0]  o_ref_prescale
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  a_free_unqual:
    assert property (o_mode == 2'h0 |-> o_ref_qualified == 4'h0)
    else $error("reference qualified in free-run");
  a_fast_bw:
    assert property (o_fast_acquire == (o_mode == 2'h1))
    else $error("fast bandwidth outside acquire");
  a_xo_lock:
    assert property ($rose(i_xo_present) |=> o_analog_loop_lock_en)
    else $error("analog loop not enabled");
  a_acq_start:
    assert property (o_mode == 2'h0 && i_ref_valid != 4'h0
      && o_analog_loop_lock_en |=> o_mode == 2'h1)
    else $error("acquire not started");
  a_hold_enter:
    assert property (o_mode == 2'h2 && i_ref_valid == 4'h0
      |=> o_mode == 2'h3 && o_holdover_load)
    else $error("holdover not entered");
  a_hold_exit:
    assert property (o_mode == 2'h3 && i_ref_valid != 4'h0
      |=> o_mode == 2'h1)
    else $error("holdover not left");
  a_hold_phase:
    assert property (o_mode == 2'h3 && $past(o_mode) == 2'h3
      |-> o_phase_lock_lost_flag)
    else $error("phase flag clear in holdover");
  a_steer_gate:
    assert property (($changed(o_osc_num) || $changed(o_ref_num))
      && !$rose(o_s_axi_bvalid) |-> $past(o_mode) == 2'h2)
    else $error("steering outside locked mode");
  a_osc_den:
    assert property (o_osc_den == dpll_pkg::DEN_FULL)
    else $error("oscillator denominator not fixed");
  a_pre_range:
    assert property (o_ref_prescale inside
      {[dpll_pkg::PRE_MIN:dpll_pkg::PRE_MAX]})
    else $error("prescale out of range");
endmodule
bind dpll_mode_ctrl dpll_mode_ctrl_assertions chk_i (.*);

// ==== test/step_pulser.sv ====
// Purpose: Far-side controller pulsing the steering pins
// Assumes: One request per call, pins idle low between pulses
// Notes:   Pulse 150 ns high, one pulse per microsecond at most
`timescale 1ns/100ps
module step_pulser (
  input  wire logic       i_sys_clk,
  input  wire logic [3:0] i_go,
  output logic      [3:0] o_pins
);
  int         cnt = 0;
  logic [3:0] sel = 4'h0;
  always @(posedge i_sys_clk) begin
    if (cnt != 0) begin
      cnt <= cnt - 1;
    end else if (i_go != 4'h0) begin
      sel <= i_go;
      cnt <= 200;
    end
  end
  // Requests during a pulse are dropped to keep the rate legal
  assign o_pins = (cnt > 170) ? sel : 4'h0;
endmodule

// ==== test/testbench.sv ====
// Purpose: Directed register and pin tests of the loop controller
// Assumes: Response readies held high, all byte lanes written
// Notes:   Mode waits rely on one-cycle transitions
`timescale 1ns/100ps
module testbench;
  logic        i_sys_clk = 1'h0, i_rst_n = 1'h0;
  logic [7:0]  i_s_axi_awaddr = 8'h00, i_s_axi_araddr = 8'h00;
  logic [31:0] i_s_axi_wdata = 32'h0, rv;
  logic [3:0]  i_s_axi_wstrb = 4'hF, i_ref_valid = 4'h0, go = 4'h0, pins;
  logic        i_s_axi_awvalid = 1'h0, i_s_axi_wvalid = 1'h0;
  logic        i_s_axi_arvalid = 1'h0, i_s_axi_bready = 1'h1;
  logic        i_s_axi_rready = 1'h1, i_xo_present = 1'h0;
  logic        i_temp_compensated_osc_present = 1'h0, i_freq_lock_det = 1'h0;
  logic        i_phase_lock_det = 1'h0;
  logic [39:0] i_tuning_word = 40'h0, o_holdover_word, o_ref_num, o_osc_num;
  logic        o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid;
  logic        o_s_axi_arready, o_s_axi_rvalid, o_analog_loop_lock_en;
  logic        o_osc_loop_lock_en, o_fast_acquire, o_holdover_load;
  logic        o_freq_lock_lost_flag, o_phase_lock_lost_flag;
  logic [1:0]  o_s_axi_bresp, o_s_axi_rresp, o_mode, rr, br;
  logic [31:0] o_s_axi_rdata;
  logic [3:0]  o_ref_qualified;
  logic [40:0] o_ref_den, o_osc_den;
  logic [4:0]  o_ref_prescale, o_osc_prescale;
  wire         i_ch1_step_up_pin = pins[0], i_ch1_step_down_pin = pins[1];
  wire         i_ch2_step_up_pin = pins[2], i_ch2_step_down_pin = pins[3];
  int          fail_count = 0, total_checks = 0, cyc = 0;
  localparam logic [31:0] C = 32'h0002_0202;
  localparam logic [39:0] TW = 40'h12_3456_789A;
  dpll_mode_ctrl #(.CHANNEL(1)) dpll_mode_ctrl_i (.*);
  step_pulser step_pulser_i (.i_sys_clk(i_sys_clk), .i_go(go), .o_pins(pins));
  always #2.5 i_sys_clk = ~i_sys_clk;
  task automatic tick(input int n);
    repeat (n) @(posedge i_sys_clk);
  endtask
  task automatic chk(input string nm, input logic [40:0] s, e);
    total_checks++;
    if (s !== e) begin
      fail_count++;
      $display("[ERR] %s exp %h got %h", nm, e, s);
    end
  endtask
  // Handshakes are judged on pre-edge values seen at the rising edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_s_axi_awaddr <= a;
    i_s_axi_wdata <= d;
    i_s_axi_awvalid <= 1'h1;
    i_s_axi_wvalid <= 1'h1;
    do begin
      @(posedge i_sys_clk);
      if (o_s_axi_awready && i_s_axi_awvalid) i_s_axi_awvalid <= 1'h0;
      if (o_s_axi_wready && i_s_axi_wvalid) i_s_axi_wvalid <= 1'h0;
    end while (o_s_axi_bvalid !== 1'h1);
    br = o_s_axi_bresp;
  endtask
  task automatic rd(input logic [7:0] a);
    i_s_axi_araddr <= a;
    i_s_axi_arvalid <= 1'h1;
    do begin
      @(posedge i_sys_clk);
      if (o_s_axi_arready && i_s_axi_arvalid) i_s_axi_arvalid <= 1'h0;
    end while (o_s_axi_rvalid !== 1'h1);
    rv = o_s_axi_rdata;
    rr = o_s_axi_rresp;
  endtask
  task automatic pulse(input logic [3:0] p);
    go <= p;
    tick(1);
    go <= 4'h0;
    tick(230);
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  always @(posedge i_sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      final_report();
    end
  end
  initial begin
    tick(6);
    i_rst_n <= 1'h1;
    tick(1);
    rd(dpll_pkg::OFF_CTRL);
    chk("ctrl", rv, dpll_pkg::RST_CTRL);
    rd(8'hFC);
    chk("resp", rr, dpll_pkg::RESP_SLVERR);
    wr(8'hFC, 32'h0);
    chk("bresp", br, dpll_pkg::RESP_SLVERR);
    chk("rden", o_ref_den, dpll_pkg::DEN_FULL);
    i_ref_valid <= 4'h1;
    tick(3);
    chk("qual", o_ref_qualified, 4'h0);
    i_xo_present <= 1'h1;
    tick(3);
    chk("analog_loop", o_analog_loop_lock_en, 1'h1);
    chk("acq", {o_mode, o_fast_acquire}, 3'h3);
    i_freq_lock_det <= 1'h1;
    i_phase_lock_det <= 1'h1;
    tick(3);
    chk("lock", {o_mode, o_fast_acquire}, 3'h4);
    chk("flags", {o_freq_lock_lost_flag, o_phase_lock_lost_flag}, 2'h0);
    wr(dpll_pkg::OFF_CTRL, C);
    chk("bok", br, dpll_pkg::RESP_OKAY);
    i_temp_compensated_osc_present <= 1'h1;
    tick(3);
    chk("olock", o_osc_loop_lock_en, 1'h1);
    $display("T1 modes done");
    wr(dpll_pkg::OFF_STEP_LO, 32'h0000_0010);
    wr(dpll_pkg::OFF_CTRL, C | 32'h04);
    wr(dpll_pkg::OFF_TRIG, 32'h0);
    chk("up", o_osc_num, 40'h10);
    wr(dpll_pkg::OFF_TRIG, 32'h1);
    wr(dpll_pkg::OFF_TRIG, 32'h1);
    chk("wrap", o_osc_num, 40'hFF_FFFF_FFF0);
    wr(dpll_pkg::OFF_CTRL, C | 32'h14);
    wr(dpll_pkg::OFF_TRIG, 32'h0);
    chk("rsel", o_ref_num, 40'h10);
    chk("osel", o_osc_num, 40'hFF_FFFF_FFF0);
    pulse(4'h1);
    chk("nopin", o_ref_num, 40'h10);
    wr(dpll_pkg::OFF_CTRL, C | 32'h1C);
    pulse(4'h1);
    chk("pinup", o_ref_num, 40'h20);
    pulse(4'h2);
    chk("pindn", o_ref_num, 40'h10);
    pulse(4'h4);
    chk("ch2", o_ref_num, 40'h10);
    wr(dpll_pkg::OFF_ONUM_LO, 32'h0000_0005);
    rd(dpll_pkg::OFF_ONUM_LO);
    chk("direct", rv, 32'h5);
    wr(dpll_pkg::OFF_CTRL, 32'h0002_1F1E);
    chk("pre", o_ref_prescale, 5'h11);
    chk("opre", o_osc_prescale, 5'h02);
    wr(dpll_pkg::OFF_RDEN_LO, 32'h3);
    chk("rden3", o_ref_den, 41'h3);
    $display("T2 steering done");
    i_tuning_word <= TW;
    wr(dpll_pkg::OFF_CTRL, 32'h0002_021F);
    tick(20);
    i_ref_valid <= 4'h0;
    i_phase_lock_det <= 1'h0;
    tick(3);
    chk("hold", o_mode, 2'h3);
    chk("hword", o_holdover_word, TW);
    chk("hflag", {o_freq_lock_lost_flag, o_phase_lock_lost_flag}, 2'h1);
    wr(dpll_pkg::OFF_TRIG, 32'h0);
    chk("gate", o_ref_num, 40'h10);
    i_ref_valid <= 4'h2;
    tick(3);
    chk("exit", o_mode, 2'h1);
    i_phase_lock_det <= 1'h1;
    tick(3);
    wr(dpll_pkg::OFF_CTRL, 32'h0002_021E);
    wr(dpll_pkg::OFF_FREE_LO, 32'h0000_0777);
    i_ref_valid <= 4'h0;
    tick(3);
    chk("fword", o_holdover_word, 40'h777);
    $display("T3 holdover done");
    final_report();
  end
endmodule
